// >>> hw/qtd_defines.svh
`ifndef QTD_DEFINES_SVH
`define QTD_DEFINES_SVH

// Bus clock phase positions inside one bus cycle of four reference cycles.
`define QTD_PH_FALL 2'h3
`define QTD_PH_START 2'h2
`define QTD_PH_FIRST 2'h0
`define QTD_PH_STEP 2'h1

// Serial link, bus steal and refusal timing, counted in reference cycles (one debug clock each).
`define QTD_BIT_SAMPLE 4'ha
`define QTD_TIMEOUT 10'h200
`define QTD_STEAL_WAIT 8'h80
`define QTD_REFUSE_DELAY 4'h8

// Serial command layout.
`define QTD_OPC_BACKGROUND 8'h90
`define QTD_OPC_MAP_BYTE_WRITE 8'hc4
`define QTD_HW_CMD_BIT 7
`define QTD_CMD_LAST_BIT 6'h07
`define QTD_PAYLOAD_LAST_BIT 6'h1f

// Debug map window and status byte.
`define QTD_MAP_PAGE 8'hff
`define QTD_STATUS_ADDR 16'hff01
`define QTD_FW_ENABLE_BIT 7

`endif

// >>> hw/qtd_pkg.sv
package qtd_pkg;

    // Queue movement codes shown around the rising bus clock edge.
    typedef enum logic [1:0] {
        QTD_MV_NONE = 2'b00,
        QTD_MV_LATCH_BUS_WORD = 2'b01,
        QTD_MV_ADVANCE_LOAD_BUS = 2'b10,
        QTD_MV_ADVANCE_LOAD_LATCH = 2'b11
    } qtd_move_type;

    // Execution start codes shown around the falling bus clock edge.
    typedef enum logic [1:0] {
        QTD_ST_NONE = 2'b00,
        QTD_ST_INTERRUPT = 2'b01,
        QTD_ST_EVEN_OPCODE_START = 2'b10,
        QTD_ST_ODD_OPCODE_START = 2'b11
    } qtd_start_type;

    // Serial receiver states.
    typedef enum logic [1:0] {
        QTD_SR_COMMAND = 2'b00,
        QTD_SR_PAYLOAD = 2'b01
    } qtd_ser_type;

    // Debug activation states.
    typedef enum logic [1:0] {
        QTD_DB_RUN = 2'b00,
        QTD_DB_PENDING = 2'b01,
        QTD_DB_ACTIVE = 2'b10,
        QTD_DB_REFUSE = 2'b11
    } qtd_dbg_type;

endpackage

// >>> hw/qtd_pin_sync.sv
`timescale 1ns/1ps

// Three-stage pin synchroniser; the output follows only when stages two and three agree.
module qtd_pin_sync (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic pin_raw,
    output logic pin_stable
);
    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic stable_q;
    logic stable_d;

    // The first stage feeds only the second, so a metastable value never reaches any logic.
    always_comb begin
        stage_d = {stage_q[1:0], pin_raw};
        stable_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : stable_q;
    end

    // The idle line level is high, so reset assumes a released pin.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage_q <= 3'h7;
            stable_q <= 1'b1;
        end else begin
            stage_q <= stage_d;
            stable_q <= stable_d;
        end
    end

    assign pin_stable = stable_q;
endmodule

// >>> hw/qtd_queue_trace_debug.sv
`timescale 1ns/1ps
`include "qtd_defines.svh"

module qtd_queue_trace_debug
    import qtd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [15:0] core_bus_data,
    input wire logic [1:0] core_move,
    input wire logic [1:0] core_start,
    input wire logic core_done,
    input wire logic core_boundary,
    input wire logic core_exit_background,
    input wire logic tag_hit,
    input wire logic halt_to_debug_instruction,
    input wire logic free_cycle,
    input wire logic [15:0] core_addr,
    input wire logic single_wire_debug_pin_in,
    output logic bus_clock_output,
    output logic [1:0] queue_status_pins,
    output logic [7:0] exec_opcode,
    output logic exec_opcode_valid,
    output logic background_debug_mode,
    output logic debug_map_select,
    output logic debug_firmware_enable,
    output logic core_freeze,
    output logic dbg_bus_req,
    output logic [15:0] dbg_bus_addr,
    output logic [15:0] dbg_bus_wdata,
    output logic fw_cmd_valid,
    output logic [7:0] fw_cmd_opcode,
    output logic single_wire_debug_pin_out,
    output logic single_wire_debug_pin_oe_n
);
    logic pin_s;

    // The host is asynchronous, so the pin is filtered before any edge is looked for.
    qtd_pin_sync u_pin_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pin_raw(single_wire_debug_pin_in),
        .pin_stable(pin_s)
    );

    // Bus clock phase and status pins.
    logic [1:0] phase_q, phase_d;
    logic bclk_q, bclk_d;
    logic [1:0] pins_q, pins_d;
    logic fall_tick, start_tick;

    // Queue state.
    logic [15:0] stage1_q, stage1_d, stage2_q, stage2_d, hold_q, hold_d;
    logic v1_q, v1_d, v2_q, v2_d, hv_q, hv_d;
    qtd_move_type mv_q, mv_d;
    qtd_start_type st_q, st_d;
    logic busy_q, busy_d;
    logic [7:0] opc_q, opc_d;
    logic opv_q, opv_d;

    // Serial receiver state.
    qtd_ser_type ser_q, ser_d;
    logic pin_prev_q, pin_prev_d;
    logic timing_q, timing_d;
    logic [3:0] smp_q, smp_d;
    logic [5:0] bit_q, bit_d;
    logic [31:0] shift_q, shift_d;
    logic [7:0] cmd_q, cmd_d;
    logic [9:0] tout_q, tout_d;
    logic bg_req_q, bg_req_d;
    logic fw_en_q, fw_en_d;
    logic fwv_q, fwv_d;
    logic [7:0] fwop_q, fwop_d;

    // Debug bus access and activation state.
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wait_q, wait_d;
    logic req_q, req_d;
    logic steal_q, steal_d;
    logic [15:0] waddr_q, waddr_d, wdata_q, wdata_d;
    qtd_dbg_type dbg_q, dbg_d;
    logic [3:0] dly_q, dly_d;
    logic map_q, map_d;
    logic pout_q, poe_n_q;
    logic bdm_q, bdm_d, frz_q, frz_d;

    assign fall_tick = (phase_q == `QTD_PH_FALL);
    assign start_tick = (phase_q == `QTD_PH_START);

    // A bus cycle spans four reference cycles: low in phases 0 and 1, high in 2 and 3.
    // Each code changes one reference cycle away from its capture edge for margin.
    // Next values are shown, so a start decided at phase two is already up in phase three.
    always_comb begin
        phase_d = phase_q + `QTD_PH_STEP;
        bclk_d = phase_d[1];
        if (phase_d == `QTD_PH_FIRST || phase_d == `QTD_PH_FALL) begin
            pins_d = st_d;
        end else begin
            pins_d = mv_d;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            phase_q <= 2'h0;
            bclk_q <= 1'b0;
            pins_q <= 2'h0;
        end else begin
            phase_q <= phase_d;
            bclk_q <= bclk_d;
            pins_q <= pins_d;
        end
    end

    // Queue movement is applied at the falling edge with the data then on the bus,
    // and the code for it is shown at the next rising edge.
    always_comb begin
        stage1_d = stage1_q;
        stage2_d = stage2_q;
        hold_d = hold_q;
        v1_d = v1_q;
        v2_d = v2_q;
        hv_d = hv_q;
        mv_d = mv_q;
        if (fall_tick) begin
            mv_d = qtd_move_type'(core_move);
            case (qtd_move_type'(core_move))
                QTD_MV_NONE: begin
                end
                QTD_MV_LATCH_BUS_WORD: begin
                    hold_d = core_bus_data;
                    hv_d = 1'b1;
                end
                QTD_MV_ADVANCE_LOAD_BUS: begin
                    stage2_d = stage1_q;
                    v2_d = v1_q;
                    stage1_d = core_bus_data;
                    v1_d = 1'b1;
                end
                QTD_MV_ADVANCE_LOAD_LATCH: begin
                    stage2_d = stage1_q;
                    v2_d = v1_q;
                    stage1_d = hold_q;
                    v1_d = hv_q;
                    hv_d = 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage1_q <= 16'h0000;
            stage2_q <= 16'h0000;
            hold_q <= 16'h0000;
            v1_q <= 1'b0;
            v2_q <= 1'b0;
            hv_q <= 1'b0;
            mv_q <= QTD_MV_NONE;
        end else begin
            stage1_q <= stage1_d;
            stage2_q <= stage2_d;
            hold_q <= hold_d;
            v1_q <= v1_d;
            v2_q <= v2_d;
            hv_q <= hv_d;
            mv_q <= mv_d;
        end
    end

    // Starts are decided one reference cycle before the falling edge, so the code
    // is already on the pins across the edge that opens the bus cycle it describes.
    // A tag or a freeze holds the start back so the tagged opcode never runs.
    always_comb begin
        st_d = st_q;
        busy_d = busy_q;
        opc_d = opc_q;
        opv_d = 1'b0;
        if (core_done) begin
            busy_d = 1'b0;
        end
        if (start_tick) begin
            st_d = QTD_ST_NONE;
            if (!busy_q && v1_q && v2_q && !tag_hit && !frz_q) begin
                case (qtd_start_type'(core_start))
                    QTD_ST_INTERRUPT: begin
                        st_d = QTD_ST_INTERRUPT;
                        busy_d = 1'b1;
                    end
                    QTD_ST_EVEN_OPCODE_START: begin
                        st_d = QTD_ST_EVEN_OPCODE_START;
                        opc_d = stage2_q[15:8];
                        opv_d = 1'b1;
                        busy_d = 1'b1;
                    end
                    QTD_ST_ODD_OPCODE_START: begin
                        st_d = QTD_ST_ODD_OPCODE_START;
                        opc_d = stage2_q[7:0];
                        opv_d = 1'b1;
                        busy_d = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= QTD_ST_NONE;
            busy_q <= 1'b0;
            opc_q <= 8'h00;
            opv_q <= 1'b0;
        end else begin
            st_q <= st_d;
            busy_q <= busy_d;
            opc_q <= opc_d;
            opv_q <= opv_d;
        end
    end

    // Serial receiver: every host falling edge opens a bit and restarts the
    // timeout; the level is taken a fixed delay later, most significant bit first.
    always_comb begin
        ser_d = ser_q;
        pin_prev_d = pin_s;
        timing_d = timing_q;
        smp_d = smp_q;
        bit_d = bit_q;
        shift_d = shift_q;
        cmd_d = cmd_q;
        tout_d = tout_q;
        bg_req_d = 1'b0;
        fw_en_d = fw_en_q;
        fwv_d = 1'b0;
        fwop_d = fwop_q;
        wr_pend_d = wr_pend_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        // The sent write is cleared first, so a write finishing in that cycle is kept.
        if (req_q) begin
            wr_pend_d = 1'b0;
        end
        if (tout_q != `QTD_TIMEOUT) begin
            tout_d = tout_q + 10'h001;
        end
        if (timing_q) begin
            smp_d = smp_q + 4'h1;
        end
        if (pin_prev_q && !pin_s) begin
            timing_d = 1'b1;
            smp_d = 4'h0;
            tout_d = 10'h000;
        end else if (tout_q == `QTD_TIMEOUT) begin
            ser_d = QTD_SR_COMMAND;
            bit_d = 6'h00;
            cmd_d = 8'h00;
            timing_d = 1'b0;
        end else if (timing_q && smp_q == `QTD_BIT_SAMPLE) begin
            timing_d = 1'b0;
            shift_d = {shift_q[30:0], pin_s};
            bit_d = bit_q + 6'h01;
            case (ser_q)
                QTD_SR_COMMAND: begin
                    if (bit_q == `QTD_CMD_LAST_BIT) begin
                        cmd_d = {shift_q[6:0], pin_s};
                        bit_d = 6'h00;
                        if (cmd_d == `QTD_OPC_BACKGROUND) begin
                            bg_req_d = 1'b1;
                        end else if (cmd_d == `QTD_OPC_MAP_BYTE_WRITE) begin
                            ser_d = QTD_SR_PAYLOAD;
                        end else if (!cmd_d[`QTD_HW_CMD_BIT] && dbg_q == QTD_DB_ACTIVE) begin
                            fwv_d = 1'b1;
                            fwop_d = cmd_d;
                        end
                    end
                end
                QTD_SR_PAYLOAD: begin
                    if (bit_q == `QTD_PAYLOAD_LAST_BIT) begin
                        ser_d = QTD_SR_COMMAND;
                        bit_d = 6'h00;
                        if (shift_q[30:15] == `QTD_STATUS_ADDR) begin
                            // Odd address, so the status byte rides in the low data byte.
                            fw_en_d = shift_q[`QTD_FW_ENABLE_BIT - 1];
                        end else begin
                            wr_pend_d = 1'b1;
                            waddr_d = shift_q[30:15];
                            wdata_d = {shift_q[14:0], pin_s};
                        end
                    end
                end
                default: begin
                    ser_d = QTD_SR_COMMAND;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ser_q <= QTD_SR_COMMAND;
            pin_prev_q <= 1'b1;
            timing_q <= 1'b0;
            smp_q <= 4'h0;
            bit_q <= 6'h00;
            shift_q <= 32'h00000000;
            cmd_q <= 8'h00;
            tout_q <= 10'h000;
            bg_req_q <= 1'b0;
            fw_en_q <= 1'b0;
            fwv_q <= 1'b0;
            fwop_q <= 8'h00;
            wr_pend_q <= 1'b0;
            waddr_q <= 16'h0000;
            wdata_q <= 16'h0000;
        end else begin
            ser_q <= ser_d;
            pin_prev_q <= pin_prev_d;
            timing_q <= timing_d;
            smp_q <= smp_d;
            bit_q <= bit_d;
            shift_q <= shift_d;
            cmd_q <= cmd_d;
            tout_q <= tout_d;
            bg_req_q <= bg_req_d;
            fw_en_q <= fw_en_d;
            fwv_q <= fwv_d;
            fwop_q <= fwop_d;
            wr_pend_q <= wr_pend_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
        end
    end

    // A pending write takes the first free bus cycle; if none comes in time the
    // core is frozen for one cycle so the write cannot starve behind a busy program.
    always_comb begin
        req_d = 1'b0;
        steal_d = 1'b0;
        wait_d = wait_q;
        if (wr_pend_q && !req_q) begin
            if (free_cycle || steal_q) begin
                req_d = 1'b1;
                wait_d = 8'h00;
            end else if (wait_q == `QTD_STEAL_WAIT - 8'h01) begin
                steal_d = 1'b1;
            end else begin
                wait_d = wait_q + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            req_q <= 1'b0;
            steal_q <= 1'b0;
            wait_q <= 8'h00;
        end else begin
            req_q <= req_d;
            steal_q <= steal_d;
            wait_q <= wait_d;
        end
    end

    // Activation: a host request waits for the next instruction boundary, a tag
    // or halt enters at once; without firmware the core is only paused briefly.
    always_comb begin
        dbg_d = dbg_q;
        dly_d = dly_q;
        case (dbg_q)
            QTD_DB_RUN: begin
                if (tag_hit || halt_to_debug_instruction) begin
                    dbg_d = fw_en_q ? QTD_DB_ACTIVE : QTD_DB_REFUSE;
                end else if (bg_req_q) begin
                    dbg_d = fw_en_q ? QTD_DB_PENDING : QTD_DB_REFUSE;
                end
                dly_d = 4'h0;
            end
            QTD_DB_PENDING: begin
                if (core_boundary) begin
                    dbg_d = QTD_DB_ACTIVE;
                end
            end
            QTD_DB_ACTIVE: begin
                if (core_exit_background) begin
                    dbg_d = QTD_DB_RUN;
                end
            end
            QTD_DB_REFUSE: begin
                dly_d = dly_q + 4'h1;
                if (dly_q == `QTD_REFUSE_DELAY - 4'h1) begin
                    dbg_d = QTD_DB_RUN;
                end
            end
            default: begin
                dbg_d = QTD_DB_RUN;
            end
        endcase
        map_d = (dbg_d == QTD_DB_ACTIVE) && (core_addr[15:8] == `QTD_MAP_PAGE);
        bdm_d = (dbg_d == QTD_DB_ACTIVE);
        frz_d = steal_d || (dbg_d == QTD_DB_REFUSE) || (dbg_d == QTD_DB_ACTIVE);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dbg_q <= QTD_DB_RUN;
            dly_q <= 4'h0;
            map_q <= 1'b0;
            bdm_q <= 1'b0;
            frz_q <= 1'b0;
            pout_q <= 1'b1;
            poe_n_q <= 1'b1;
        end else begin
            dbg_q <= dbg_d;
            dly_q <= dly_d;
            map_q <= map_d;
            bdm_q <= bdm_d;
            frz_q <= frz_d;
            pout_q <= 1'b1;
            poe_n_q <= 1'b1; // This end only receives, so the pin is left released.
        end
    end

    assign bus_clock_output = bclk_q;
    assign queue_status_pins = pins_q;
    assign exec_opcode = opc_q;
    assign exec_opcode_valid = opv_q;
    assign background_debug_mode = bdm_q;
    assign debug_map_select = map_q;
    assign debug_firmware_enable = fw_en_q;
    assign core_freeze = frz_q;
    assign dbg_bus_req = req_q;
    assign dbg_bus_addr = waddr_q;
    assign dbg_bus_wdata = wdata_q;
    assign fw_cmd_valid = fwv_q;
    assign fw_cmd_opcode = fwop_q;
    assign single_wire_debug_pin_out = pout_q;
    assign single_wire_debug_pin_oe_n = poe_n_q;
endmodule

// >>> sim/qtd_checker.sv
`timescale 1ns/1ps

// Ties trace pins and debug outputs to their causes, from the top ports only.
module qtd_checker (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [1:0] core_move,
    input wire logic [1:0] core_start,
    input wire logic [15:0] core_addr,
    input wire logic tag_hit,
    input wire logic bus_clock_output,
    input wire logic [1:0] queue_status_pins,
    input wire logic background_debug_mode,
    input wire logic debug_map_select,
    input wire logic core_freeze,
    input wire logic fw_cmd_valid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Phase two is the first high bus clock cycle, phase three the second.
    sequence s_ph2;
        $rose(bus_clock_output);
    endsequence
    sequence s_ph3;
        bus_clock_output && $past(bus_clock_output);
    endsequence
    property p_bclk;
        s_ph2 |-> bus_clock_output[*2] ##1 (!bus_clock_output)[*2] ##1 bus_clock_output;
    endproperty
    a_bclk: assert property (p_bclk) else $error("bus clock shape");
    property p_hold;
        s_ph2 |-> $stable(queue_status_pins);
    endproperty
    a_hold: assert property (p_hold) else $error("code moves at rise");
    property p_move;
        s_ph3 |-> ##2 queue_status_pins == $past(core_move, 2);
    endproperty
    a_move: assert property (p_move) else $error("movement code");
    property p_start;
        s_ph2 |=> queue_status_pins == 2'h0 || queue_status_pins == $past(core_start);
    endproperty
    a_start: assert property (p_start) else $error("start code");
    property p_block;
        s_ph2 ##0 (tag_hit || core_freeze) |=> queue_status_pins == 2'h0;
    endproperty
    a_block: assert property (p_block) else $error("blocked start shown");
    property p_map;
        debug_map_select == (background_debug_mode && $past(core_addr[15:8]) == 8'hff);
    endproperty
    a_map: assert property (p_map) else $error("debug map decode");
    property p_fw;
        fw_cmd_valid |-> background_debug_mode;
    endproperty
    a_fw: assert property (p_fw) else $error("firmware command outside");
    // Outside background mode a freeze is only a brief pause.
    property p_frz;
        core_freeze && !background_debug_mode |-> ##[1:8] (!core_freeze || background_debug_mode);
    endproperty
    a_frz: assert property (p_frz) else $error("core frozen too long");
endmodule

bind qtd_queue_trace_debug qtd_checker chk_u (.ref_clk, .nrst, .core_move, .core_start, .core_addr,
    .tag_hit, .bus_clock_output, .queue_status_pins, .background_debug_mode, .debug_map_select,
    .core_freeze, .fw_cmd_valid);

// >>> sim/qtd_host_model.sv
`timescale 1ns/1ps

// Development host on the single debug wire; the pull-up gives high when released.
module qtd_host_model (
    input wire logic ref_clk,
    output logic pin
);
    initial pin = 1'b1;
    // A one is a short low pulse, a zero stays low past the sample point.
    task automatic send(input logic [39:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            pin = 1'b0;
            repeat (v[i] ? 4 : 13) @(negedge ref_clk);
            pin = 1'b1;
            repeat (v[i] ? 12 : 3) @(negedge ref_clk);
        end
    endtask
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps

// Self-checking bench for queue trace and debug entry.
module tb_top
    import qtd_pkg::*;
;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] core_bus_data = 16'h0000;
    logic [15:0] core_addr = 16'h0000;
    logic [1:0] core_move = 2'h0;
    logic [1:0] core_start = 2'h0;
    logic core_done = 1'b0;
    logic core_boundary = 1'b0;
    logic core_exit_background = 1'b0;
    logic tag_hit = 1'b0;
    logic halt_to_debug_instruction = 1'b0;
    logic free_cycle = 1'b0;
    logic host_pin, pin_in, pin_out, pin_oe_n, bus_clock_output, exec_opcode_valid;
    logic background_debug_mode, debug_map_select, debug_firmware_enable, core_freeze;
    logic dbg_bus_req, fw_cmd_valid;
    logic [1:0] queue_status_pins;
    logic [7:0] exec_opcode, fw_cmd_opcode;
    logic [7:0] fw_seen = 8'h00;
    logic [15:0] dbg_bus_addr, dbg_bus_wdata;
    logic [31:0] req_seen = 32'h0;
    int n_fail = 0;
    int compares = 0;

    always #50 ref_clk = ~ref_clk;
    // Open-drain wire: either party may pull it low.
    assign pin_in = host_pin & (pin_oe_n | pin_out);

    qtd_host_model host_u (.ref_clk(ref_clk), .pin(host_pin));
    qtd_queue_trace_debug dut_u (.ref_clk, .nrst, .core_bus_data, .core_move, .core_start,
        .core_done, .core_boundary, .core_exit_background, .tag_hit, .halt_to_debug_instruction,
        .free_cycle, .core_addr, .single_wire_debug_pin_in(pin_in), .bus_clock_output,
        .queue_status_pins, .exec_opcode, .exec_opcode_valid, .background_debug_mode,
        .debug_map_select, .debug_firmware_enable, .core_freeze, .dbg_bus_req, .dbg_bus_addr,
        .dbg_bus_wdata, .fw_cmd_valid, .fw_cmd_opcode, .single_wire_debug_pin_out(pin_out),
        .single_wire_debug_pin_oe_n(pin_oe_n));

    // Pulses can land while the host is still sending, so they are kept here.
    always @(posedge ref_clk) begin
        if (fw_cmd_valid) fw_seen = fw_cmd_opcode;
        if (dbg_bus_req) req_seen = {dbg_bus_addr, dbg_bus_wdata};
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
    endtask

    // Trace capture at the far side: the queue is rebuilt from the bus word seen at
    // each falling bus clock edge and from the codes on the status pins.
    logic [15:0] tr_bus = 16'h0000;
    logic [15:0] tr_hold = 16'h0000;
    logic [15:0] tr_s1 = 16'h0000;
    logic [15:0] tr_s2 = 16'h0000;

    always @(posedge bus_clock_output) begin
        if (queue_status_pins == QTD_MV_LATCH_BUS_WORD) begin
            tr_hold = tr_bus;
        end
        if (queue_status_pins[1]) begin
            tr_s2 = tr_s1;
            tr_s1 = queue_status_pins[0] ? tr_hold : tr_bus;
        end
    end

    // A started opcode must be the byte that the rebuilt second stage holds.
    always @(negedge bus_clock_output) begin
        if (queue_status_pins[1]) begin
            chk(exec_opcode, queue_status_pins[0] ? tr_s2[7:0] : tr_s2[15:8]);
        end
        tr_bus = core_bus_data;
    end

    task automatic wait_bdm(input logic exp);
        repeat (40) if (background_debug_mode !== exp) @(negedge ref_clk);
        chk(background_debug_mode, exp);
    endtask

    // One bus cycle: start code read at phase three, movement code at phase one.
    task automatic cyc(input logic [1:0] mv, input logic [1:0] st, input logic [15:0] dat,
        input logic dn, input logic [1:0] exp_st);
        @(posedge bus_clock_output);
        @(negedge ref_clk);
        core_move = mv;
        core_start = st;
        core_bus_data = dat;
        @(negedge ref_clk);
        chk(queue_status_pins, exp_st);
        chk(exec_opcode_valid, exp_st[1]);
        @(negedge ref_clk);
        core_done = dn;
        core_start = 2'h0;
        core_move = 2'h0;
        @(negedge ref_clk);
        core_done = 1'b0;
        chk(queue_status_pins, mv);
    endtask

    // Early starts are refused until both stages hold words; a busy core refuses too.
    task automatic t_queue();
        cyc(QTD_MV_ADVANCE_LOAD_BUS, QTD_ST_EVEN_OPCODE_START, 16'h1122, 1'b1, 2'h0);
        cyc(QTD_MV_LATCH_BUS_WORD, QTD_ST_NONE, 16'h3344, 1'b1, 2'h0);
        cyc(QTD_MV_ADVANCE_LOAD_LATCH, QTD_ST_ODD_OPCODE_START, 16'h5566, 1'b1, 2'h0);
        cyc(QTD_MV_NONE, QTD_ST_EVEN_OPCODE_START, 16'h0000, 1'b0, 2'h2);
        chk(exec_opcode, 8'h11);
        cyc(QTD_MV_NONE, QTD_ST_ODD_OPCODE_START, 16'h0000, 1'b1, 2'h0);
        cyc(QTD_MV_ADVANCE_LOAD_BUS, QTD_ST_ODD_OPCODE_START, 16'h7788, 1'b1, 2'h3);
        chk(exec_opcode, 8'h22);
        cyc(QTD_MV_NONE, QTD_ST_EVEN_OPCODE_START, 16'h0000, 1'b1, 2'h2);
        chk(exec_opcode, 8'h33);
        cyc(QTD_MV_NONE, QTD_ST_INTERRUPT, 16'h0000, 1'b1, 2'h1);
    endtask

    // Entry without firmware enable only freezes the core for a moment.
    task automatic t_refuse();
        pulse(halt_to_debug_instruction);
        repeat (3) @(negedge ref_clk);
        chk(core_freeze, 1'b1);
        repeat (20) @(negedge ref_clk);
        chk({core_freeze, background_debug_mode}, 2'h0);
        host_u.send(8'h05, 8);
        repeat (5) @(negedge ref_clk);
        chk(fw_seen, 8'h00);
    endtask

    // Enable firmware, a write that must steal a cycle on a busy bus, then one
    // that a free bus cycle takes long before any steal could happen.
    task automatic t_host();
        host_u.send(40'hc4ff010080, 40);
        repeat (20) @(negedge ref_clk);
        chk(debug_firmware_enable, 1'b1);
        host_u.send(40'hc41234abcd, 40);
        repeat (200) @(negedge ref_clk);
        chk(req_seen, 32'h1234abcd);
        free_cycle = 1'b1;
        host_u.send(40'hc456789abc, 40);
        repeat (4) @(negedge ref_clk);
        chk(req_seen, 32'h56789abc);
        free_cycle = 1'b0;
    endtask

    // Stale bits are dropped after an idle gap; the host entry waits for a boundary.
    task automatic t_enter();
        host_u.send(4'hf, 4);
        repeat (600) @(negedge ref_clk);
        host_u.send(8'h90, 8);
        repeat (30) @(negedge ref_clk);
        chk(background_debug_mode, 1'b0);
        pulse(core_boundary);
        wait_bdm(1'b1);
        core_addr = 16'hff10;
        repeat (2) @(negedge ref_clk);
        chk(debug_map_select, 1'b1);
        host_u.send(8'h05, 8);
        repeat (5) @(negedge ref_clk);
        chk(fw_seen, 8'h05);
        pulse(core_exit_background);
        wait_bdm(1'b0);
        chk(debug_map_select, 1'b0);
    endtask

    // The tag and the halt instruction each enter once firmware is on.
    task automatic t_sources();
        pulse(tag_hit);
        wait_bdm(1'b1);
        pulse(core_exit_background);
        wait_bdm(1'b0);
        pulse(halt_to_debug_instruction);
        wait_bdm(1'b1);
        pulse(core_exit_background);
        wait_bdm(1'b0);
    endtask

    initial begin
        repeat (3) @(negedge ref_clk);
        chk({queue_status_pins, debug_firmware_enable, background_debug_mode, pin_oe_n, pin_out}, 6'h03);
        nrst = 1'b1;
        t_queue();
        t_refuse();
        t_host();
        t_enter();
        t_sources();
        report_and_stop();
    end

    // About two and a half times the expected run, so a stuck wait cannot hang it.
    initial begin
        #800000;
        n_fail++;
        report_and_stop();
    end
endmodule
